/* fsb_flag_bank_regs.vh */
`ifndef FSB_FLAG_BANK_REGS_VH
`define FSB_FLAG_BANK_REGS_VH

// ************************************************************
// Register byte addresses
// ************************************************************
`define FSB_ADDR_STATUS 8'h00
`define FSB_ADDR_CONTROL 8'h04
`define FSB_ADDR_COMMAND 8'h08
`define FSB_ADDR_PROTECT 8'h0c

// ************************************************************
// Status byte fields
// ************************************************************
`define FSB_ST_BUSY 0
`define FSB_ST_LATCH 1
`define FSB_ST_SWP_LO 2
`define FSB_ST_SWP_HI 3
`define FSB_ST_ULTRA_DEEP_SLEEP_STATE 4
`define FSB_ST_FAIL 5
`define FSB_ST_DPD 6
`define FSB_ST_LOCK 7
`define FSB_SWP_NONE 2'h0
`define FSB_SWP_SOME 2'h1
`define FSB_SWP_ALL 2'h3
`define FSB_STATUS_SLEEP 8'hff

// ************************************************************
// Control register fields and reset values
// ************************************************************
`define FSB_CTL_AUTO_ULTRA 0
`define FSB_CTL_TERM_EN 1
`define FSB_SECTORS 8
`define FSB_SECT_RESET 8'hff
`define FSB_SECT_ALL 8'hff

// ************************************************************
// Command register fields
// ************************************************************
`define FSB_CMD_OP_HI 7
`define FSB_CMD_SECT_HI 15
`define FSB_CMD_SECT_LO 8
`define FSB_CMD_COMPLETE 16

// ************************************************************
// Command codes
// ************************************************************
`define FSB_OP_WREN 8'h06
`define FSB_OP_WRDI 8'h04
`define FSB_OP_WRSR 8'h01
`define FSB_OP_PROG 8'h02
`define FSB_OP_ERASE 8'h20
`define FSB_OP_CHIP 8'h60
`define FSB_OP_PROT 8'h36
`define FSB_OP_UNPROT 8'h39
`define FSB_OP_ULTRA_DEEP_SLEEP_STATE 8'h79
`define FSB_OP_TERM 8'hf0
`define FSB_OP_RSTEN 8'h66
`define FSB_OP_RST 8'h99

// ************************************************************
// Engine operation kinds
// ************************************************************
`define FSB_KIND_PROG 2'h0
`define FSB_KIND_ERASE 2'h1
`define FSB_KIND_CHIP 2'h2

`endif

/* fsb_retention_bit.v */
`timescale 1ns/1ps
// ************************************************************
// Retention cell: cleared only by power-on or an explicit clear
// ************************************************************
module fsb_retention_bit (
   input wire clock,
   input wire resetn,
   input wire loadEn,
   input wire loadVal,
   input wire clearEn,
   output wire value
);
   reg bit_ff;
   reg nxt_bit;

   always @* begin
      nxt_bit = bit_ff;
      if (clearEn) begin
         nxt_bit = 1'b0;
      end
      // Fresh result wins over a clear in the same cycle
      if (loadEn) begin
         nxt_bit = loadVal;
      end
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         bit_ff <= 1'b0;
      end else begin
         bit_ff <= nxt_bit;
      end
   end

   assign value = bit_ff;
endmodule // fsb_retention_bit

/* fsb_flag_bank.v */
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "fsb_flag_bank_regs.vh"
// Contract
// - A byte failing program or erase sets the failure flag
// - Rejected program or erase leaves the failure flag alone
// - Every completed program or erase rewrites the failure flag
// - Flag survives pin or in-band wake after automatic sleep
// - Flag undefined after explicit sleep exit; host must not rely
// - Power cycle clears the failure flag
// - Automatic sleep keeps flag; only power cycle or exit from command-entered sleep clears it
// - Sleep exit restores volatile defaults; flag too after command
// - Reset or terminate during an operation never sets the flag
// - Terminate while executing leaves the flag unchanged
// - Flag undefined after in-band, pin, or software reset
// - Without automatic sleep, sleep exit clears the flag
// - Sleep indicator is 1 only in ultra-deep sleep
// - Protect summary reflects the per-sector protect bits
// - Latch low: write-type commands ignored
// - Latch is 0 after power-up and any reset
// - Latch clears when write-type operations complete or abort
// - Incomplete or unknown command keeps a set latch
// - Abort clears latch only after the whole command arrived
// - Busy flag is 1 while an internal operation runs
// - Summary encodes 00 none, 01 some, 11 all
// - Status byte reads all ones during ultra-deep sleep
module fsb_flag_bank (
   input wire clock,
   input wire resetn,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire hwResetN,
   input wire inbandReset,
   input wire engineDone,
   input wire engineFail,
   output reg opStart,
   output reg opAbort,
   output reg [1:0] opKind,
   output reg [2:0] opSector,
   output reg [7:0] statusByte
);
   // ************************************************************
   // State
   // ************************************************************
   reg latch_ff;
   reg busy_ff;
   reg ultra_deep_sleep_state_ff;
   reg udpdExplicit_ff;
   reg autoUltra_ff;
   reg termEn_ff;
   reg rstArmed_ff;
   reg [7:0] sect_ff;
   reg nxt_latch;
   reg nxt_busy;
   reg nxt_ultra_deep_sleep_state;
   reg nxt_udpdExplicit;
   reg nxt_autoUltra;
   reg nxt_termEn;
   reg nxt_rstArmed;
   reg [7:0] nxt_sect;
   reg nxt_opStart;
   reg nxt_opAbort;
   reg [1:0] nxt_opKind;
   reg [2:0] nxt_opSector;
   reg [31:0] nxt_prdata;
   reg nxt_pslverr;
   reg [7:0] nxt_status;
   reg nxt_fail;
   reg failLoad;
   reg failClear;
   reg devReset;
   reg [1:0] soft_protect_summary;
   wire failFlag;

   // ************************************************************
   // Bus decode
   // ************************************************************
   wire access = psel & penable & pready;
   wire wrEv = access & pwrite;
   wire isStatus = (paddr == `FSB_ADDR_STATUS);
   wire isControl = (paddr == `FSB_ADDR_CONTROL);
   wire isCommand = (paddr == `FSB_ADDR_COMMAND);
   wire isProtect = (paddr == `FSB_ADDR_PROTECT);
   wire mapped = isStatus | isControl | isCommand | isProtect;
   wire cmdEv = wrEv & isCommand;
   wire [7:0] cmdOp = pwdata[`FSB_CMD_OP_HI:0];
   wire [7:0] cmdSect = pwdata[`FSB_CMD_SECT_HI:`FSB_CMD_SECT_LO];
   wire cmdWhole = pwdata[`FSB_CMD_COMPLETE];
   wire sectAll = (cmdSect == `FSB_SECT_ALL);
   wire [2:0] sectIdx = cmdSect[2:0];
   wire sectInRange = (cmdSect < `FSB_SECTORS) | sectAll;
   wire isArrayOp = (cmdOp == `FSB_OP_PROG) | (cmdOp == `FSB_OP_ERASE) |
      (cmdOp == `FSB_OP_CHIP);
   wire isWriteCmd = isArrayOp | (cmdOp == `FSB_OP_WRSR) |
      (cmdOp == `FSB_OP_PROT) | (cmdOp == `FSB_OP_UNPROT);

   // ************************************************************
   // Protection summary
   // ************************************************************
   always @* begin
      if (nxt_sect == 8'h00) begin
         soft_protect_summary = `FSB_SWP_NONE;
      end else if (nxt_sect == `FSB_SECT_ALL) begin
         soft_protect_summary = `FSB_SWP_ALL;
      end else begin
         soft_protect_summary = `FSB_SWP_SOME;
      end
   end

   // ************************************************************
   // Failure flag storage
   // ************************************************************
   fsb_retention_bit u_failRet (
      .clock(clock),
      .resetn(resetn),
      .loadEn(failLoad),
      .loadVal(engineFail),
      .clearEn(failClear),
      .value(failFlag)
   );

   // ************************************************************
   // Command and flag sequencing
   // ************************************************************
   always @* begin
      nxt_latch = latch_ff;
      nxt_busy = busy_ff;
      nxt_ultra_deep_sleep_state = ultra_deep_sleep_state_ff;
      nxt_udpdExplicit = udpdExplicit_ff;
      nxt_autoUltra = autoUltra_ff;
      nxt_termEn = termEn_ff;
      nxt_rstArmed = rstArmed_ff;
      nxt_sect = sect_ff;
      nxt_opStart = 1'b0;
      nxt_opAbort = 1'b0;
      nxt_opKind = opKind;
      nxt_opSector = opSector;
      failLoad = 1'b0;
      failClear = 1'b0;
      devReset = 1'b0;

      if (ultra_deep_sleep_state_ff) begin
         // Only a reset wakes the part; all else is ignored
         if (!hwResetN || inbandReset) begin
            nxt_ultra_deep_sleep_state = 1'b0;
            nxt_udpdExplicit = 1'b0;
            nxt_latch = 1'b0;
            nxt_busy = 1'b0;
            nxt_rstArmed = 1'b0;
            nxt_sect = `FSB_SECT_RESET;
            nxt_termEn = 1'b0;
            nxt_autoUltra = 1'b0;
            // Auto entry keeps the result; command entry clears it
            failClear = udpdExplicit_ff;
         end
      end else if (!hwResetN || inbandReset) begin
         devReset = 1'b1;
      end else begin
         // Operation finished by the array engine
         if (busy_ff && engineDone) begin
            nxt_busy = 1'b0;
            failLoad = 1'b1;
            nxt_latch = 1'b0;
            if (autoUltra_ff) begin
               nxt_ultra_deep_sleep_state = 1'b1;
               nxt_udpdExplicit = 1'b0;
               nxt_autoUltra = 1'b0;
            end
         end
         if (cmdEv) begin
            // Any complete command other than the reset pair disarms it
            nxt_rstArmed = 1'b0;
            if (!cmdWhole) begin
               nxt_rstArmed = rstArmed_ff;
            end else if (cmdOp == `FSB_OP_RSTEN) begin
               nxt_rstArmed = 1'b1;
            end else if (cmdOp == `FSB_OP_RST && rstArmed_ff) begin
               devReset = 1'b1;
            end else if (cmdOp == `FSB_OP_TERM) begin
               if (termEn_ff && busy_ff && !engineDone) begin
                  nxt_busy = 1'b0;
                  nxt_opAbort = 1'b1;
                  nxt_latch = 1'b0;
                  // No load of the failure flag here
               end
            end else if (cmdOp == `FSB_OP_WREN) begin
               if (!busy_ff) begin
                  nxt_latch = 1'b1;
               end
            end else if (cmdOp == `FSB_OP_WRDI) begin
               if (!busy_ff) begin
                  nxt_latch = 1'b0;
               end
            end else if (cmdOp == `FSB_OP_ULTRA_DEEP_SLEEP_STATE) begin
               if (!busy_ff) begin
                  nxt_ultra_deep_sleep_state = 1'b1;
                  nxt_udpdExplicit = 1'b1;
               end
            end else if (isWriteCmd && latch_ff && !busy_ff) begin
               // Full command taken: latch clears on finish or abort
               nxt_latch = 1'b0;
               if (cmdOp == `FSB_OP_PROT && sectInRange) begin
                  nxt_sect = sectAll ? `FSB_SECT_ALL :
                     (sect_ff | (8'h01 << sectIdx));
               end else if (cmdOp == `FSB_OP_UNPROT && sectInRange) begin
                  nxt_sect = sectAll ? 8'h00 :
                     (sect_ff & ~(8'h01 << sectIdx));
               end else if (isArrayOp) begin
                  // Protected or bad target aborts with no flag update
                  if (cmdOp == `FSB_OP_CHIP) begin
                     if (sect_ff == 8'h00) begin
                        nxt_latch = 1'b1;
                        nxt_busy = 1'b1;
                        nxt_opStart = 1'b1;
                        nxt_opKind = `FSB_KIND_CHIP;
                        nxt_opSector = 3'h0;
                     end
                  end else if (cmdSect < `FSB_SECTORS &&
                     !sect_ff[sectIdx]) begin
                     nxt_latch = 1'b1;
                     nxt_busy = 1'b1;
                     nxt_opStart = 1'b1;
                     nxt_opKind = (cmdOp == `FSB_OP_PROG) ?
                        `FSB_KIND_PROG : `FSB_KIND_ERASE;
                     nxt_opSector = sectIdx;
                  end
               end
            end
            // Otherwise a write-type command with latch low is dropped
            // with no effect beyond disarming the reset pair
         end
         if (wrEv && isControl && !busy_ff) begin
            nxt_autoUltra = pwdata[`FSB_CTL_AUTO_ULTRA];
            nxt_termEn = pwdata[`FSB_CTL_TERM_EN];
         end
      end

      if (devReset) begin
         // Reset aborts a running operation; flag keeps its value
         nxt_latch = 1'b0;
         nxt_busy = 1'b0;
         nxt_opAbort = busy_ff;
         nxt_opStart = 1'b0;
         nxt_rstArmed = 1'b0;
         nxt_ultra_deep_sleep_state = 1'b0;
         nxt_udpdExplicit = 1'b0;
         failLoad = 1'b0;
      end
   end

   // ************************************************************
   // Status byte and read data
   // ************************************************************
   // Result as it stands after this edge, so busy and flag update together
   always @* begin
      nxt_fail = failFlag;
      if (failClear) begin
         nxt_fail = 1'b0;
      end
      if (failLoad) begin
         nxt_fail = engineFail;
      end
   end

   always @* begin
      nxt_status = `FSB_STATUS_SLEEP;
      if (!nxt_ultra_deep_sleep_state) begin
         nxt_status = 8'h00;
         nxt_status[`FSB_ST_BUSY] = nxt_busy;
         nxt_status[`FSB_ST_LATCH] = nxt_latch;
         nxt_status[`FSB_ST_SWP_HI] = soft_protect_summary[1];
         nxt_status[`FSB_ST_SWP_LO] = soft_protect_summary[0];
         nxt_status[`FSB_ST_ULTRA_DEEP_SLEEP_STATE] = 1'b0;
         nxt_status[`FSB_ST_FAIL] = nxt_fail;
         nxt_status[`FSB_ST_DPD] = 1'b0;
         nxt_status[`FSB_ST_LOCK] = 1'b0;
      end
   end

   always @* begin
      nxt_prdata = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      if (psel && !penable) begin
         if (!mapped) begin
            nxt_pslverr = 1'b1;
         end else if (!pwrite && isStatus) begin
            nxt_prdata = {24'h00_0000, statusByte};
         end else if (!pwrite && isControl) begin
            nxt_prdata = {30'h0000_0000, termEn_ff, autoUltra_ff};
         end else if (!pwrite && isProtect) begin
            nxt_prdata = {24'h00_0000, sect_ff};
         end
      end else if (pready) begin
         nxt_prdata = 32'h0000_0000;
      end else begin
         nxt_prdata = prdata;
         nxt_pslverr = pslverr;
      end
   end

   // ************************************************************
   // Flip-flops
   // ************************************************************
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         latch_ff <= 1'b0;
         busy_ff <= 1'b0;
         ultra_deep_sleep_state_ff <= 1'b0;
         udpdExplicit_ff <= 1'b0;
         autoUltra_ff <= 1'b0;
         termEn_ff <= 1'b0;
         rstArmed_ff <= 1'b0;
         sect_ff <= `FSB_SECT_RESET;
         opStart <= 1'b0;
         opAbort <= 1'b0;
         opKind <= `FSB_KIND_PROG;
         opSector <= 3'h0;
         statusByte <= 8'h00;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         latch_ff <= nxt_latch;
         busy_ff <= nxt_busy;
         ultra_deep_sleep_state_ff <= nxt_ultra_deep_sleep_state;
         udpdExplicit_ff <= nxt_udpdExplicit;
         autoUltra_ff <= nxt_autoUltra;
         termEn_ff <= nxt_termEn;
         rstArmed_ff <= nxt_rstArmed;
         sect_ff <= nxt_sect;
         opStart <= nxt_opStart;
         opAbort <= nxt_opAbort;
         opKind <= nxt_opKind;
         opSector <= nxt_opSector;
         statusByte <= nxt_status;
         prdata <= nxt_prdata;
         pready <= psel & ~penable;
         pslverr <= nxt_pslverr;
      end
   end
endmodule // fsb_flag_bank

/* fsb_flag_bank_sva.sv */
`timescale 1ns/1ps
module fsb_flag_bank_sva (
   input wire clock,
   input wire resetn,
   input wire [7:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire hwResetN,
   input wire inbandReset,
   input wire engineDone,
   input wire engineFail,
   input wire opStart,
   input wire opAbort,
   input wire [1:0] opKind,
   input wire [2:0] opSector,
   input wire [7:0] statusByte
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // ************************************************************
   // Sequences
   // ************************************************************
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_pin_reset;
      !hwResetN [*2];
   endsequence
   sequence s_done;
      engineDone && statusByte[0] && hwResetN && !inbandReset;
   endsequence
   sequence s_quiet_pin;
      !hwResetN && !engineDone && !$past(engineDone) && !statusByte[4];
   endsequence
   // ************************************************************
   // Properties
   // ************************************************************
   property p_ready;
      s_setup |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("Ready not one cycle");
   property p_sleep_ones;
      statusByte[4] |-> statusByte == 8'hff;
   endproperty
   a_sleep_ones: assert property (p_sleep_ones)
      else $error("Sleep status not all ones");
   property p_deep_bit;
      statusByte[6] |-> statusByte[4];
   endproperty
   a_deep_bit: assert property (p_deep_bit)
      else $error("Deep bit outside sleep");
   property p_summary;
      statusByte[3:2] != 2'b10;
   endproperty
   a_summary: assert property (p_summary)
      else $error("Reserved summary code");
   property p_busy;
      opStart |-> ##[1:2] statusByte[0];
   endproperty
   a_busy: assert property (p_busy)
      else $error("Busy missing after start");
   property p_latch_gate;
      opStart |-> $past(statusByte[1]);
   endproperty
   a_latch_gate: assert property (p_latch_gate)
      else $error("Start without latch");
   property p_latch_clear;
      $fell(statusByte[0]) |-> !statusByte[1];
   endproperty
   a_latch_clear: assert property (p_latch_clear)
      else $error("Latch kept after busy fell");
   property p_result;
      s_done |-> ##2 (statusByte[5] == $past(engineFail, 2) || statusByte[4]);
   endproperty
   a_result: assert property (p_result)
      else $error("Failure flag not refreshed");
   property p_pin_keep;
      s_quiet_pin |=> ##1 statusByte[5] == $past(statusByte[5], 2);
   endproperty
   a_pin_keep: assert property (p_pin_keep)
      else $error("Pin reset moved failure flag");
   property p_pin_clear;
      s_pin_reset |=> !statusByte[1] && !statusByte[0];
   endproperty
   a_pin_clear: assert property (p_pin_clear)
      else $error("Latch or busy after pin reset");
endmodule // fsb_flag_bank_sva

bind fsb_flag_bank fsb_flag_bank_sva fsb_flag_bank_sva_i (.clock(clock),
   .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .hwResetN(hwResetN), .inbandReset(inbandReset),
   .engineDone(engineDone), .engineFail(engineFail), .opStart(opStart),
   .opAbort(opAbort), .opKind(opKind), .opSector(opSector),
   .statusByte(statusByte));

/* fsb_engine_model.sv */
`timescale 1ns/1ps
module fsb_engine_model (
   input wire clock,
   input wire resetn,
   input wire opStart,
   input wire opAbort,
   input wire [7:0] delay,
   input wire failIn,
   output logic engineDone,
   output wire engineFail
);
   logic [7:0] cnt;
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt <= 8'h00;
         engineDone <= 1'b0;
      end else begin
         engineDone <= (cnt == 8'h01) && !opAbort;
         if (opAbort)
            cnt <= 8'h00;
         else if (opStart)
            cnt <= delay;
         else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
      end
   end
   // Result line shows the opposite outside the done pulse
   assign engineFail = engineDone ? failIn : !failIn;
endmodule // fsb_engine_model

/* testbench.sv */
`timescale 1ns/1ps
`include "fsb_flag_bank_regs.vh"
module testbench;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic hwResetN = 1'b1;
   logic inbandReset = 1'b0;
   logic [7:0] engDelay = 8'h04;
   logic engFailIn = 1'b0;
   wire [31:0] prdata;
   wire pready, pslverr, engineDone, engineFail, opStart, opAbort;
   wire [1:0] opKind;
   wire [2:0] opSector;
   wire [7:0] statusByte;
   logic [31:0] rd;
   logic err;
   logic [1:0] lastKind = 2'h0;
   logic [2:0] lastSect = 3'h0;
   int starts = 0;
   int aborts = 0;
   int miscompares = 0;
   int num_checks = 0;

   always #25 clock = ~clock;

   fsb_flag_bank fsb_flag_bank_i (.clock(clock), .resetn(resetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hwResetN(hwResetN), .inbandReset(inbandReset),
      .engineDone(engineDone), .engineFail(engineFail),
      .opStart(opStart), .opAbort(opAbort), .opKind(opKind),
      .opSector(opSector), .statusByte(statusByte));
   fsb_engine_model fsb_engine_model_i (.clock(clock), .resetn(resetn),
      .opStart(opStart), .opAbort(opAbort), .delay(engDelay),
      .failIn(engFailIn), .engineDone(engineDone),
      .engineFail(engineFail));

   always @(posedge clock) begin
      if (opStart === 1'b1) begin
         starts++;
         lastKind = opKind;
         lastSect = opSector;
      end
      if (opAbort === 1'b1)
         aborts++;
   end

   // ************************************************************
   // Bus and check tasks
   // ************************************************************
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      begin
         @(posedge clock);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'b1;
         do begin
            @(posedge clock);
         end while (pready !== 1'b1);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      begin
         num_checks++;
         if (g !== e) begin
            miscompares++;
            $display("BAD at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask

   task automatic cmd(input logic [7:0] op, input logic [7:0] s);
      apb(1'b1, `FSB_ADDR_COMMAND, {15'h0, 1'b1, s, op});
   endtask

   task automatic st(input logic [7:0] e);
      begin
         repeat (2) @(posedge clock);
         apb(1'b0, `FSB_ADDR_STATUS, 32'h0);
         chk(rd, {24'h0, e});
      end
   endtask

   task automatic poll(input logic [7:0] e);
      int n;
      begin
         n = 0;
         repeat (2) @(posedge clock);
         do begin
            apb(1'b0, `FSB_ADDR_STATUS, 32'h0);
            n++;
         end while (rd[0] !== 1'b0 && n < 100);
         chk(rd, {24'h0, e});
      end
   endtask

   task automatic pulse(input int k);
      begin
         @(posedge clock);
         if (k == 1) begin
            hwResetN <= 1'b0;
            repeat (2) @(posedge clock);
            hwResetN <= 1'b1;
         end else begin
            inbandReset <= 1'b1;
            @(posedge clock);
            inbandReset <= 1'b0;
         end
      end
   endtask

   task automatic run_op(input logic [7:0] op, input logic [7:0] s,
         input logic f, input logic [1:0] k, input logic [7:0] e, int ns);
      int n0;
      logic [2:0] es;
      begin
         n0 = starts;
         es = (k == `FSB_KIND_CHIP) ? 3'h0 : s[2:0];
         engFailIn <= f;
         cmd(`FSB_OP_WREN, 8'h00);
         cmd(op, s);
         poll(e);
         chk({30'h0, lastKind}, {30'h0, k});
         chk(starts - n0, ns);
         if (ns == 1)
            chk({29'h0, lastSect}, {29'h0, es});
      end
   endtask

   task automatic power_up;
      begin
         resetn <= 1'b0;
         repeat (16) @(posedge clock);
         resetn <= 1'b1;
      end
   endtask

   task automatic report_and_stop;
      begin
         $display("Checks %0d, mismatches %0d", num_checks, miscompares);
         if (miscompares == 0 && num_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_init;
      begin
         st(8'h0c);
         apb(1'b0, `FSB_ADDR_PROTECT, 32'h0);
         chk(rd, 32'hff);
         apb(1'b0, 8'h10, 32'h0);
         chk({31'h0, err}, 32'h1);
         apb(1'b1, `FSB_ADDR_STATUS, 32'hff);
         st(8'h0c);
         cmd(`FSB_OP_UNPROT, 8'hff);
         st(8'h0c);
         cmd(`FSB_OP_WREN, 8'h00);
         st(8'h0e);
         cmd(`FSB_OP_UNPROT, 8'hff);
         st(8'h00);
         cmd(`FSB_OP_WREN, 8'h00);
         cmd(`FSB_OP_PROT, 8'h03);
         st(8'h04);
         apb(1'b0, `FSB_ADDR_PROTECT, 32'h0);
         chk(rd, 32'h08);
         $display("t_init done");
      end
   endtask

   task automatic t_latch;
      begin
         cmd(`FSB_OP_WREN, 8'h00);
         apb(1'b1, `FSB_ADDR_COMMAND, {16'h0, 8'h00, `FSB_OP_PROG});
         st(8'h06);
         cmd(`FSB_OP_WRDI, 8'h00);
         st(8'h04);
         cmd(`FSB_OP_WREN, 8'h00);
         cmd(`FSB_OP_WRSR, 8'h00);
         st(8'h04);
         $display("t_latch done");
      end
   endtask

   task automatic t_ops;
      begin
         run_op(`FSB_OP_PROG, 8'h00, 1'b1, `FSB_KIND_PROG, 8'h24, 1);
         run_op(`FSB_OP_ERASE, 8'h01, 1'b0, `FSB_KIND_ERASE, 8'h04, 1);
         run_op(`FSB_OP_PROG, 8'h02, 1'b1, `FSB_KIND_PROG, 8'h24, 1);
         run_op(`FSB_OP_PROG, 8'h03, 1'b0, `FSB_KIND_PROG, 8'h24, 0);
         run_op(`FSB_OP_CHIP, 8'hff, 1'b0, `FSB_KIND_PROG, 8'h24, 0);
         cmd(`FSB_OP_WREN, 8'h00);
         cmd(`FSB_OP_UNPROT, 8'hff);
         run_op(`FSB_OP_CHIP, 8'hff, 1'b0, `FSB_KIND_CHIP, 8'h00, 1);
         $display("t_ops done");
      end
   endtask

   task automatic t_abort;
      int k;
      int a0;
      begin
         apb(1'b1, `FSB_ADDR_CONTROL, 32'h2);
         engDelay <= 8'h40;
         engFailIn <= 1'b1;
         for (k = 0; k < 4; k++) begin
            a0 = aborts;
            cmd(`FSB_OP_WREN, 8'h00);
            cmd(`FSB_OP_PROG, 8'h00);
            st(8'h03);
            if (k == 0)
               cmd(`FSB_OP_TERM, 8'h00);
            else if (k < 3)
               pulse(k);
            else begin
               cmd(`FSB_OP_RSTEN, 8'h00);
               cmd(`FSB_OP_RST, 8'h00);
            end
            st(8'h00);
            chk(aborts - a0, 1);
         end
         engDelay <= 8'h04;
         $display("t_abort done");
      end
   endtask

   task automatic t_sleep;
      begin
         apb(1'b1, `FSB_ADDR_CONTROL, 32'h1);
         engFailIn <= 1'b1;
         cmd(`FSB_OP_WREN, 8'h00);
         cmd(`FSB_OP_PROG, 8'h00);
         repeat (12) @(posedge clock);
         st(8'hff);
         cmd(`FSB_OP_WREN, 8'h00);
         pulse(1);
         st(8'h2c);
         apb(1'b0, `FSB_ADDR_CONTROL, 32'h0);
         chk(rd, 32'h0);
         cmd(`FSB_OP_ULTRA_DEEP_SLEEP_STATE, 8'h00);
         st(8'hff);
         pulse(2);
         st(8'h0c);
         $display("t_sleep done");
      end
   endtask

   task automatic t_power;
      begin
         cmd(`FSB_OP_WREN, 8'h00);
         cmd(`FSB_OP_UNPROT, 8'hff);
         run_op(`FSB_OP_PROG, 8'h00, 1'b1, `FSB_KIND_PROG, 8'h20, 1);
         power_up;
         st(8'h0c);
         $display("t_power done");
      end
   endtask

   initial begin
      power_up;
      t_init;
      t_latch;
      t_ops;
      t_abort;
      t_sleep;
      t_power;
      report_and_stop;
   end

   initial begin
      #1000000;
      miscompares++;
      report_and_stop;
   end
endmodule // testbench
